// file: core/ssv_supervisor.sv
// Speed separation supervisor: scanner zones, robot speed and stop control.
// Assumes scanner, robot and switch inputs synchronous to clk_i.
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module ssv_supervisor
	import ssv_pkg::*;
#(
	parameter int WIN_CYC = SEQ_WIN_CYC // Qualify window, shorten in simulation
) (
	input wire logic clk_i, // System clock, 20 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire ssv_sense_t sense_i, // Scanner zones and robot speed
	input wire logic estop_btn_i, // Emergency stop pressed
	input wire logic reset_btn_i, // Manual reset pushbutton
	input wire logic mode_select_input_a_i, // Mode selector channel A
	input wire logic mode_select_input_b_i, // Mode selector channel B
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic [3:0] wb_adr_i, // Wishbone byte address
	input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	output logic reduced_speed_req_o, // Request reduced speed from robot
	output logic prot_stop_o, // Protective stop to robot
	output logic estop_o, // Emergency stop to robot
	output logic [1:0] zone_set_o // Zone set select {b, a}
);
	// =====================================================
	// Declarations
	ssv_state_t state_ff; // Supervisor state
	ssv_state_t nxt_state; // Next state
	ssv_mode_t mode_ff; // Mode seen last cycle
	ssv_mode_t mode_now; // Mode decoded this cycle
	logic btn_ff; // Reset button last cycle
	logic press; // Reset button rising edge
	logic zone2_ff; // Zone set 2 selected
	logic nxt_zone2; // Next zone set choice
	logic red_req_ff; // Reduced speed request
	logic pstop_ff; // Protective stop request
	logic estop_ff; // Emergency stop latched
	logic viol_ff; // Violation seen, sticky until reset
	logic [1:0] zsel_ff; // Zone select channels
	logic viol; // Exit sequence violated now
	logic force_lock; // Emergency, mode change or fault
	logic in_run; // Running-mode state
	logic qual_done; // Warning held with reduced speed
	logic exit_done; // Warning held after protective clear
	logic auto_en; // Automated reset permitted
	logic warn;
	logic prot;
	logic red;
	ssv_status_t status;

	assign warn = sense_i.warn_int;
	assign prot = sense_i.prot_int;
	assign red = sense_i.robot_reduced;
	assign press = reset_btn_i && !btn_ff;
	assign in_run = state_ff inside {ST_RUN, ST_PSTOP, ST_EXIT};

	// =====================================================
	// Mode decode
	always_comb begin
		if (mode_select_input_a_i && !mode_select_input_b_i) begin
			mode_now = MODE_RUN;
		end else if (!mode_select_input_a_i && mode_select_input_b_i) begin
			mode_now = MODE_PROG;
		end else begin
			mode_now = MODE_FAULT;
		end
	end

	// Any change or fault drops to the safe state
	assign force_lock = estop_btn_i || mode_now != mode_ff || mode_now == MODE_FAULT;

	// =====================================================
	// Input history
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_ff <= MODE_FAULT;
			btn_ff <= 1'b0;
		end else begin
			mode_ff <= mode_now;
			btn_ff <= reset_btn_i;
		end
	end

	// =====================================================
	// Qualifying timers
	ssv_timer #(.CYCLES(WIN_CYC)) u_qual (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(state_ff == ST_RUN && warn && red),
		.done_o(qual_done)
	);

	ssv_timer #(.CYCLES(WIN_CYC)) u_exit (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(state_ff == ST_EXIT && warn),
		.done_o(exit_done)
	);

	// =====================================================
	// State transitions
	always_comb begin
		nxt_state = state_ff;
		viol = 1'b0;
		if (force_lock) begin
			nxt_state = ST_LOCK;
		end else begin
			case (state_ff)
				ST_LOCK: begin
					// Manual release, running mode needs clear zones
					if (press && (mode_now == MODE_PROG || (!warn && !prot))) begin
						nxt_state = (mode_now == MODE_PROG) ? ST_PROG : ST_RUN;
					end
				end
				ST_RUN: begin
					if (prot) begin
						nxt_state = ST_PSTOP;
					end
				end
				ST_PSTOP: begin
					if (!prot) begin
						nxt_state = ST_EXIT;
					end
				end
				ST_EXIT: begin
					if (prot) begin
						nxt_state = ST_PSTOP;
					end else if (!warn) begin
						viol = 1'b1;
						nxt_state = ST_LOCK;
					end else if (exit_done) begin
						nxt_state = auto_en ? ST_RUN : ST_LOCK;
					end
				end
				ST_PROG: begin
					nxt_state = ST_PROG;
				end
				default: begin
					nxt_state = ST_LOCK;
				end
			endcase
		end
	end

	// =====================================================
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ST_LOCK;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// =====================================================
	// Zone set choice
	always_comb begin
		if (!(nxt_state inside {ST_RUN, ST_PSTOP, ST_EXIT})) begin
			nxt_zone2 = 1'b0;
		end else if (!red) begin
			nxt_zone2 = 1'b0;
		end else if (!warn && !prot) begin
			nxt_zone2 = 1'b0;
		end else if (qual_done && warn) begin
			nxt_zone2 = 1'b1;
		end else begin
			nxt_zone2 = zone2_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zone2_ff <= 1'b0;
			zsel_ff <= ZSEL_SET1;
		end else begin
			zone2_ff <= nxt_zone2;
			zsel_ff <= nxt_zone2 ? ZSEL_SET2 : ZSEL_SET1;
		end
	end

	// =====================================================
	// Robot requests
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			red_req_ff <= 1'b0;
			pstop_ff <= 1'b1;
		end else begin
			red_req_ff <= in_run && (warn || prot);
			pstop_ff <= nxt_state inside {ST_LOCK, ST_PSTOP, ST_EXIT};
		end
	end

	// Emergency stop latch, cleared only by the manual release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			estop_ff <= 1'b0;
			viol_ff <= 1'b0;
		end else if (estop_btn_i || viol) begin
			estop_ff <= 1'b1;
			viol_ff <= viol_ff || viol;
		end else if (state_ff == ST_LOCK && nxt_state != ST_LOCK) begin
			estop_ff <= 1'b0;
			viol_ff <= 1'b0;
		end
	end

	// =====================================================
	// Register slave
	assign status = '{viol_seen: viol_ff, estop: estop_ff, pstop: pstop_ff, red_req: red_req_ff,
		zone2: zone2_ff, mode: mode_ff, state: state_ff};

	ssv_wb_regs u_regs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(wb_cyc_i),
		.stb_i(wb_stb_i),
		.we_i(wb_we_i),
		.adr_i(wb_adr_i),
		.sel_i(wb_sel_i),
		.dat_i(wb_dat_i),
		.status_i(status),
		.dat_o(wb_dat_o),
		.ack_o(wb_ack_o),
		.auto_en_o(auto_en)
	);

	assign reduced_speed_req_o = red_req_ff;
	assign prot_stop_o = pstop_ff;
	assign estop_o = estop_ff;
	assign zone_set_o = zsel_ff;

	// =====================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_exit_bad;
		state_ff == ST_EXIT && !prot && !warn && !force_lock;
	endsequence

	sequence s_lock_release;
		state_ff == ST_LOCK ##1 state_ff != ST_LOCK;
	endsequence

	a_reset_zone1: assert property (disable iff (1'b0) rst_i |=> zone_set_o == ZSEL_SET1)
		else $error("zone set 1 not selected after reset");
	a_warn_request: assert property (in_run && warn |=> reduced_speed_req_o)
		else $error("reduced speed not requested");
	a_zone2_cause: assert property ($rose(zone2_ff) |-> $past(qual_done && red && warn))
		else $error("zone set 2 without qualified cause");
	a_normal_zone1: assert property (!red |=> !zone2_ff && zone_set_o == ZSEL_SET1)
		else $error("zone set 2 at normal speed");
	a_request_hold: assert property (in_run && warn ##1 in_run && warn |=> reduced_speed_req_o)
		else $error("reduced request dropped");
	a_stop_entry: assert property (state_ff == ST_RUN && prot |=> prot_stop_o ##1 prot_stop_o)
		else $error("protective stop not driven");
	a_stop_hold: assert property (state_ff == ST_PSTOP && prot && !force_lock |=> state_ff == ST_PSTOP)
		else $error("stop released while occupied");
	a_zone_return: assert property (zone2_ff && !warn && !prot |=> !zone2_ff)
		else $error("zone set 2 kept after zones cleared");
	a_request_clear: assert property (reduced_speed_req_o |-> $past(warn || prot))
		else $error("reduced request without zone");
	a_exit_violate: assert property (s_exit_bad |=> state_ff == ST_LOCK && estop_o)
		else $error("violation did not trigger emergency stop");
	a_auto_reset: assert property (state_ff == ST_EXIT ##1 state_ff == ST_RUN |-> $past(exit_done && auto_en))
		else $error("automated reset without valid exit");
	a_manual_release: assert property (s_lock_release |-> $past(press))
		else $error("safe state left without reset press");
	a_zone_compl: assert property (zone_set_o[0] != zone_set_o[1])
		else $error("zone select channels not complementary");
	// Emergency stop wins over every state and is latched
	a_estop_lock: assert property (estop_btn_i |=> state_ff == ST_LOCK && estop_o && prot_stop_o)
		else $error("emergency stop not latched in safe state");
	a_mode_fault: assert property (mode_now == MODE_FAULT || mode_now != mode_ff |=> state_ff == ST_LOCK)
		else $error("fault or mode change not locked");
endmodule : ssv_supervisor

// file: core/ssv_pkg.sv
// Shared constants and types for the speed separation supervisor.
// Assumes a single 20 MHz system clock and a synchronous active-high reset.
package ssv_pkg;
	// =====================================================
	// Timing
	localparam int CLK_HZ = 20_000_000; // System clock rate
	localparam int SEQ_WIN_MS = 500; // Zone-switch and exit-check window
	localparam int SEQ_WIN_CYC = SEQ_WIN_MS * (CLK_HZ / 1000); // Window in cycles

	// =====================================================
	// Register map (byte offsets on the bus)
	localparam logic [3:0] OFS_CTRL = 4'h0; // Control word
	localparam logic [3:0] OFS_STATUS = 4'h4; // Status word
	localparam int CTRL_AUTO_BIT = 0; // Automated reset permitted
	localparam logic [31:0] CTRL_RST = 32'h0000_0001; // Control reset value
	localparam logic [31:0] DAT_ZERO = 32'h0000_0000; // Unmapped read value

	// =====================================================
	// Zone set select channels {b, a}
	localparam logic [1:0] ZSEL_SET1 = 2'h1; // Large field set
	localparam logic [1:0] ZSEL_SET2 = 2'h2; // Small field set

	// =====================================================
	// Supervisor states, one-hot
	typedef enum logic [4:0] {
		ST_LOCK = 5'h01, // Safe state, waits for manual reset
		ST_RUN = 5'h02, // Running mode, robot moving
		ST_PSTOP = 5'h04, // Protective stop, zone occupied
		ST_EXIT = 5'h08, // Exit sequence check
		ST_PROG = 5'h10 // Programming mode
	} ssv_state_t;

	// Decoded selector position
	typedef enum logic [1:0] {
		MODE_FAULT = 2'h0, // Invalid combination
		MODE_RUN = 2'h1, // Running mode
		MODE_PROG = 2'h2 // Programming mode
	} ssv_mode_t;

	// Scanner and robot feedback
	typedef struct packed {
		logic warn_int; // Warning zone interrupted
		logic prot_int; // Active protective zone interrupted
		logic robot_reduced; // Robot reports reduced speed active
	} ssv_sense_t;

	// Status word contents, low bits of the status register
	typedef struct packed {
		logic viol_seen; // Exit sequence violated since last reset
		logic estop; // Emergency stop latched
		logic pstop; // Protective stop request
		logic red_req; // Reduced speed request
		logic zone2; // Zone set 2 selected
		ssv_mode_t mode; // Decoded mode
		ssv_state_t state; // Supervisor state
	} ssv_status_t;
endpackage : ssv_pkg

// file: core/ssv_timer.sv
// Qualifying timer: counts while its condition holds, restarts when it drops.
// Assumes the caller keeps run_i stable per cycle; done_o stays high while run_i holds.
`timescale 1ns/1ps
module ssv_timer #(
	parameter int CYCLES = 16
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic run_i, // Condition being qualified
	output logic done_o // Condition held CYCLES cycles
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = CYCLES[W-1:0];

	logic [W-1:0] cnt_ff; // Cycles the condition has held

	// =====================================================
	// Counter saturates at the window length
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_ff <= '0;
		end else if (cnt_ff != LAST) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	assign done_o = (cnt_ff == LAST);

	a_timer_restart: assert property (@(posedge clk_i) disable iff (rst_i)
		!run_i |=> !done_o) else $error("timer done without condition");
endmodule : ssv_timer

// file: core/ssv_wb_regs.sv
// Wishbone classic register slave: control word and status word.
// Assumes a single-cycle classic master that holds its request until ack.
`timescale 1ns/1ps
module ssv_wb_regs
	import ssv_pkg::*;
(
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic cyc_i, // Bus cycle
	input wire logic stb_i, // Strobe
	input wire logic we_i, // Write enable
	input wire logic [3:0] adr_i, // Byte address
	input wire logic [3:0] sel_i, // Byte lanes
	input wire logic [31:0] dat_i, // Write data
	input wire ssv_status_t status_i, // Live block state
	output logic [31:0] dat_o, // Read data
	output logic ack_o, // Acknowledge
	output logic auto_en_o // Automated reset permitted
);
	logic [31:0] ctrl_ff; // Control register
	logic [31:0] rdat_ff; // Registered read data
	logic ack_ff; // Registered acknowledge
	logic req; // New request this cycle

	assign req = cyc_i && stb_i && !ack_ff;

	// =====================================================
	// Acknowledge one cycle after the request, drop the next
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req;
		end
	end

	// =====================================================
	// Control write commits at the edge the master samples ack, low byte lane only carries bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= CTRL_RST;
		end else if (cyc_i && stb_i && ack_ff && we_i && adr_i == OFS_CTRL && sel_i[0]) begin
			ctrl_ff <= {31'h0000_0000, dat_i[CTRL_AUTO_BIT]};
		end
	end

	// =====================================================
	// Read mux, unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_ff <= DAT_ZERO;
		end else if (req && !we_i) begin
			case (adr_i)
				OFS_CTRL: begin
					rdat_ff <= ctrl_ff;
				end
				OFS_STATUS: begin
					rdat_ff <= {{(32 - $bits(ssv_status_t)){1'b0}}, status_i};
				end
				default: begin
					rdat_ff <= DAT_ZERO;
				end
			endcase
		end
	end

	assign dat_o = rdat_ff;
	assign ack_o = ack_ff;
	assign auto_en_o = ctrl_ff[CTRL_AUTO_BIT];

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o) else $error("ack held two cycles");
endmodule : ssv_wb_regs

// file: sim/ssv_robot_model.sv
// Robot controller model: feeds back reduced speed with a short or long lag.
// Assumes the supervisor outputs are registered on clk_i.
`timescale 1ns/1ps
module ssv_robot_model (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic red_req_i, // Reduced speed request
	input wire logic stop_i, // Protective or emergency stop
	input wire logic slow_i, // Long feedback lag
	input wire logic fail_i, // Speed limit cannot be kept
	input wire logic prog_i, // Programming mode selected
	input wire logic enab_center_i, // Enabling device in center position
	output logic reduced_o, // Reduced speed active
	output logic moving_o // Arm in motion
);
	logic [3:0] lag_ff; // Request history, one bit per cycle

	// =====================================================
	// Feedback path
	// Shift the request so feedback lags by one or four cycles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lag_ff <= 4'h0;
		end else begin
			lag_ff <= {lag_ff[2:0], red_req_i};
		end
	end

	// A robot that cannot hold the limit stops itself and reports no reduced speed
	assign reduced_o = (slow_i ? lag_ff[3] : lag_ff[0]) & ~fail_i;
	// Restarts on its own once released, speed still follows the request
	// In programming mode the arm only moves while the enabling device sits in center
	assign moving_o = ~stop_i & ~fail_i & (~prog_i | enab_center_i);
endmodule : ssv_robot_model

// file: sim/ssv_supervisor_tb_top.sv
// Self-checking bench for the speed separation supervisor.
// Assumes the package, design files and robot model are compiled first.
`timescale 1ns/1ps
module ssv_supervisor_tb_top
	import ssv_pkg::*;
;
	localparam int WIN = 8; // Shortened qualify window
	logic clk_i = 1'b0; // Bench clock
	logic rst_i = 1'b1; // Reset, high for 16 cycles
	logic warn = 1'b0, prot = 1'b0, estop_btn = 1'b0, reset_btn = 1'b0; // Scanner and switches
	logic mode_a = 1'b1, mode_b = 1'b0, slow = 1'b0, fail = 1'b0; // Selector and robot knobs
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus control
	logic [3:0] adr = 4'h0, sel = 4'h0; // Bus address and lanes
	logic [31:0] dat = 32'h0, rdat, exp_d; // Bus data
	logic ack, red_req, pstop, estop, rob_red, moving; // Design and robot outputs
	logic enab = 1'b1; // Enabling device in center position
	logic [1:0] zone_set; // Zone select pair
	logic [4:0] exp_o; // Noted output vector
	logic [4:0] out_q[$]; // Noted outputs
	logic [31:0] rd_q[$]; // Noted read data
	logic [1:0] modes[4] = '{2'h0, 2'h3, 2'h1, 2'h2}; // Selector {a, b} table
	ssv_sense_t sense; // Packed scanner and robot feedback
	int error_cnt = 0, total_checks = 0, cycles = 0; // Counters

	assign sense = '{warn_int: warn, prot_int: prot, robot_reduced: rob_red};
	always #25 clk_i = ~clk_i;

	ssv_supervisor #(.WIN_CYC(WIN)) ssv_supervisor_inst (.clk_i(clk_i), .rst_i(rst_i), .sense_i(sense),
		.estop_btn_i(estop_btn), .reset_btn_i(reset_btn), .mode_select_input_a_i(mode_a),
		.mode_select_input_b_i(mode_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .reduced_speed_req_o(red_req),
		.prot_stop_o(pstop), .estop_o(estop), .zone_set_o(zone_set));
	ssv_robot_model ssv_robot_model_inst (.clk_i(clk_i), .rst_i(rst_i), .red_req_i(red_req),
		.stop_i(pstop | estop), .slow_i(slow), .fail_i(fail), .prog_i(~mode_a & mode_b), .enab_center_i(enab),
		.reduced_o(rob_red), .moving_o(moving));

	// =====================================================
	// Driver tasks, entered just after a rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
	endtask : step
	// Note {zone_set, req, pstop, estop} for the watcher
	task automatic chk(input logic [4:0] v);
		out_q.push_back(v);
		step(1);
	endtask : chk
	task automatic press;
		reset_btn <= 1'b1;
		step(2);
		reset_btn <= 1'b0;
		step(4);
	endtask : press
	// Classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
		input logic [31:0] e);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		if (!w) rd_q.push_back(e);
		// Ends when ack is sampled high; the hang guard stops the run if it never comes
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		step(1);
	endtask : wb
	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	// =====================================================
	// Watcher: settled outputs, compared against the oldest note
	always @(negedge clk_i) begin
		if (!rst_i) begin
			total_checks++;
			if (zone_set !== ZSEL_SET1 && zone_set !== ZSEL_SET2) begin
				error_cnt++;
				$display("unexpected zone_set_o expected 01 or 10 seen %b", zone_set);
			end
		end
		if (out_q.size() > 0) begin
			exp_o = out_q.pop_front();
			total_checks++;
			if ({zone_set, red_req, pstop, estop} !== exp_o) begin
				error_cnt++;
				$display("unexpected outputs expected %b seen %b", exp_o, {zone_set, red_req, pstop, estop});
			end
		end
		if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) begin
			exp_d = rd_q.pop_front();
			total_checks++;
			if (rdat !== exp_d) begin
				error_cnt++;
				$display("unexpected wb_dat_o expected %h seen %h", exp_d, rdat);
			end
		end
	end

	// Hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// =====================================================
	// Main sequence
	initial begin
		void'($urandom(32'h08d0));
		step(16);
		rst_i <= 1'b0;
		step(1);
		chk({ZSEL_SET1, 3'h2});
		wb(1'b0, OFS_STATUS, 4'hf, 32'h0, 32'h0000_0221);
		wb(1'b0, OFS_CTRL, 4'hf, 32'h0, CTRL_RST);
		wb(1'b1, 4'hc, 4'hf, $urandom, 32'h0);
		wb(1'b0, 4'hc, 4'hf, 32'h0, DAT_ZERO);
		step(20);
		chk({ZSEL_SET1, 3'h2});
		press();
		chk({ZSEL_SET1, 3'h0});
		// Approach with a lagging robot that first cannot hold the limit
		slow <= 1'b1;
		fail <= 1'b1;
		warn <= 1'b1;
		step(2);
		chk({ZSEL_SET1, 3'h4});
		step(20);
		chk({ZSEL_SET1, 3'h4});
		fail <= 1'b0;
		step(4);
		chk({ZSEL_SET1, 3'h4});
		step(12);
		chk({ZSEL_SET2, 3'h4});
		prot <= 1'b1;
		step(2);
		chk({ZSEL_SET2, 3'h6});
		step(30);
		chk({ZSEL_SET2, 3'h6});
		prot <= 1'b0;
		step(3);
		chk({ZSEL_SET2, 3'h6});
		step(20);
		chk({ZSEL_SET2, 3'h4});
		warn <= 1'b0;
		slow <= 1'b0;
		step(3);
		chk({ZSEL_SET1, 3'h0});
		// Every selector position, each change forcing the safe state
		foreach (modes[i]) begin
			{mode_a, mode_b} <= modes[i];
			step(2);
			chk({ZSEL_SET1, 3'h2});
			press();
			chk({ZSEL_SET1, 1'b0, ~^modes[i], 1'b0});
			if (modes[i] == 2'h1) begin
				prot <= 1'b1;
				step(3);
				chk({ZSEL_SET1, 3'h0});
				wb(1'b0, OFS_STATUS, 4'hf, 32'h0, 32'h0000_0050);
				total_checks += 2;
				if (moving !== 1'b1) begin
					error_cnt++;
					$display("unexpected moving_o expected 1 seen %b", moving);
				end
				enab <= 1'b0;
				step(1);
				if (moving !== 1'b0) begin
					error_cnt++;
					$display("unexpected moving_o expected 0 seen %b", moving);
				end
				enab <= 1'b1;
				prot <= 1'b0;
			end
		end
		// Automated reset refused when disabled, lane 0 guards the control bit
		wb(1'b1, OFS_CTRL, 4'($urandom) | 4'h1, $urandom & 32'hffff_fffe, 32'h0);
		wb(1'b1, OFS_CTRL, 4'he, 32'h1, 32'h0);
		wb(1'b0, OFS_CTRL, 4'hf, 32'h0, 32'h0);
		warn <= 1'b1;
		step(20);
		prot <= 1'b1;
		step(3);
		prot <= 1'b0;
		step(20);
		warn <= 1'b0;
		step(3);
		chk({ZSEL_SET1, 3'h2});
		press();
		wb(1'b1, OFS_CTRL, 4'h1, CTRL_RST, 32'h0);
		// Emergency stop held through a press, then released
		estop_btn <= 1'b1;
		step(2);
		press();
		chk({ZSEL_SET1, 3'h3});
		estop_btn <= 1'b0;
		step(2);
		chk({ZSEL_SET1, 3'h3});
		press();
		chk({ZSEL_SET1, 3'h0});
		// Exit without the warning-zone pass
		warn <= 1'b1;
		step(2);
		prot <= 1'b1;
		step(3);
		warn <= 1'b0;
		prot <= 1'b0;
		step(4);
		chk({ZSEL_SET1, 3'h3});
		wb(1'b0, OFS_STATUS, 4'hf, 32'h0, 32'h0000_0e21);
		press();
		chk({ZSEL_SET1, 3'h0});
		print_verdict();
	end
endmodule : ssv_supervisor_tb_top
